// ### pkg/adcsq_regs.svh
// Register offsets, field positions and timing counts of the sequencer.
// Assumes a byte-addressed Avalon-MM slave; each register is one word.
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// Register indices; byte address is four times the index
`define ADCSQ_IDX_CR1      6'h34
`define ADCSQ_IDX_CR2      6'h35
`define ADCSQ_IDX_RES_LO   6'h36
`define ADCSQ_IDX_RES_HI   6'h37

// First control register fields
`define ADCSQ_START_BIT    7
`define ADCSQ_MODE_HI      6
`define ADCSQ_MODE_LO      5
`define ADCSQ_AIN_BIT      4
`define ADCSQ_CHAN_HI      3

// Second control register fields
`define ADCSQ_EOC_BIT      7
`define ADCSQ_BUSY_BIT     6
`define ADCSQ_TIME_HI      2

// Mode field encodings
`define ADCSQ_MODE_OFF     2'h0
`define ADCSQ_MODE_SINGLE  2'h1
`define ADCSQ_MODE_REPEAT  2'h3

// Conversion time in core clock periods, per time-select code
`define ADCSQ_CYC_T0       11'h027
`define ADCSQ_CYC_T1       11'h04E
`define ADCSQ_CYC_T2       11'h09C
`define ADCSQ_CYC_T3       11'h138
`define ADCSQ_CYC_T4       11'h270
`define ADCSQ_CYC_T5       11'h4E0

`endif

// ### pkg/adcsq_pkg.sv
// Types shared by the conversion sequencer.
// Assumes the register header is included by the design file.
`default_nettype none

package adcsq_pkg;

    // Sequencer states
    typedef enum logic {
        ADCSQ_IDLE,
        ADCSQ_CONV
    } adcsq_state_t;

    // Whole state of the sequencer
    typedef struct packed {
        adcsq_state_t st;     // Sequencer state
        logic         start;  // Start request bit
        logic [1:0]   mode;   // Operating mode
        logic         ain;    // Analog input enable
        logic [3:0]   chan;   // Channel select
        logic [2:0]   tsel;   // Conversion time select
        logic         eoc;    // End-of-conversion flag
        logic         busy;   // Busy flag
        logic [9:0]   res;    // Last stored result
        logic         lo_rd;  // Lower byte read, upper not yet
        logic [10:0]  cnt;    // Cycles left in conversion
        logic         irq;    // Completion pulse
        logic         ack;    // Bus answer phase
        logic         wait_r; // Waitrequest
        logic [31:0]  rdata;  // Read data
    } adcsq_state_s_t;

endpackage

`default_nettype wire

// ### src/adcsq_seq.sv
// Conversion sequencer of a 10-bit converter with an Avalon-MM slave.
// Assumes the analog core presents a settled code on i_analog_code at
// the end of the conversion time, and i_low_power is high while the
// chip sits in a stop, idle or slow mode.
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
`default_nettype none

module adcsq_seq
    import adcsq_pkg::*;
(
    input  wire logic        i_ref_clk,             // Core clock
    input  wire logic        i_resetn,              // Async reset, low
    input  wire logic [7:0]  i_avs_address,         // Byte address
    input  wire logic        i_avs_read,            // Read strobe
    input  wire logic        i_avs_write,           // Write strobe
    input  wire logic [31:0] i_avs_writedata,       // Write data
    input  wire logic [3:0]  i_avs_byteenable,      // Byte lanes
    input  wire logic [9:0]  i_analog_code,         // Code from core
    input  wire logic        i_low_power,           // Low-power mode
    output logic [31:0]      o_avs_readdata,        // Read data
    output logic             o_avs_waitrequest,     // Wait
    output logic             o_conv_done_irq,       // Completion pulse
    output logic             o_conv_busy_flag,      // Converting
    output logic [3:0]       o_channel_select,      // Channel to core
    output logic             o_analog_input_enable, // Input switch
    output logic             o_ref_connect          // Reference switch
);

    // Whole state and its next value, plus per-edge decode
    adcsq_state_s_t s_q;   // Registered state
    adcsq_state_s_t s_d;   // Next state
    logic [5:0]     idx;   // Word index
    logic           acc_w; // Write taken this edge
    logic           acc_r; // Read taken this edge
    logic           comp;  // Conversion ends this edge
    logic           go;    // Start accepted this edge
    logic           stop0; // Mode 00 written this edge

    // Bus decode: word index and strobes taken at the answer edge
    assign idx   = i_avs_address[7:2];
    assign acc_w = i_avs_write && s_q.ack;
    assign acc_r = i_avs_read && s_q.ack;

    // Conversion length per time-select code
    function automatic logic [10:0] conv_len(input logic [2:0] t);
        case (t)
            3'h0:    conv_len = `ADCSQ_CYC_T0;
            3'h1:    conv_len = `ADCSQ_CYC_T1;
            3'h2:    conv_len = `ADCSQ_CYC_T2;
            3'h3:    conv_len = `ADCSQ_CYC_T3;
            3'h4:    conv_len = `ADCSQ_CYC_T4;
            default: conv_len = `ADCSQ_CYC_T5; // Reserved codes run longest
        endcase
    endfunction

    // Next-state logic: bus, sequencer, stops.
    // A completion that lands between the lower and the upper result read
    // is dropped, so software sees a torn pair only from one on the lower read's snapshot edge; the upper read
    // closes the pair again. Low power is a level and is applied last, so
    // it wins over any completion and over every written field but channel and time select in the same cycle.
    always_comb begin
        // Defaults: hold every field, no events this edge
        s_d   = s_q;
        comp  = 1'b0;
        go    = 1'b0;
        stop0 = 1'b0;
        s_d.irq = 1'b0;
        // One wait cycle, then answer for a single cycle
        s_d.ack    = (i_avs_read || i_avs_write) && !s_q.ack;
        s_d.wait_r = !s_d.ack;
        // Snapshot read data during the wait cycle
        if (i_avs_read && !s_q.ack) begin
            case (idx)
                `ADCSQ_IDX_CR1: s_d.rdata = {24'h000000, s_q.start, s_q.mode,
                                             s_q.ain, s_q.chan};
                `ADCSQ_IDX_CR2: s_d.rdata = {24'h000000, s_q.eoc, s_q.busy,
                                             3'h0, s_q.tsel};
                `ADCSQ_IDX_RES_LO: s_d.rdata = {24'h000000, s_q.res[7:0]};
                `ADCSQ_IDX_RES_HI: s_d.rdata = {30'h00000000, s_q.res[9:8]};
                default: s_d.rdata = 32'h00000000; // Unmapped reads zero
            endcase
        end
        // Register writes on the answer edge, low byte lane only
        if (acc_w && i_avs_byteenable[0]) begin
            case (idx)
                // Control one: start, mode, input enable, channel
                `ADCSQ_IDX_CR1: begin
                    s_d.start = i_avs_writedata[`ADCSQ_START_BIT];
                    s_d.mode  = i_avs_writedata[`ADCSQ_MODE_HI:`ADCSQ_MODE_LO];
                    s_d.ain   = i_avs_writedata[`ADCSQ_AIN_BIT];
                    s_d.chan  = i_avs_writedata[`ADCSQ_CHAN_HI:0];
                    stop0     = (s_d.mode == `ADCSQ_MODE_OFF);
                end
                // Control two: time select only, flags are read-only
                `ADCSQ_IDX_CR2: begin
                    s_d.tsel = i_avs_writedata[`ADCSQ_TIME_HI:0];
                end
                default: begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
        // Result reads steer the end flag
        if (acc_r && idx == `ADCSQ_IDX_RES_HI) begin
            s_d.eoc   = 1'b0;
            s_d.lo_rd = 1'b0;
        end else if (acc_r && idx == `ADCSQ_IDX_RES_LO) begin
            s_d.lo_rd = 1'b1;
        end
        // Sequencer
        case (s_q.st)
            ADCSQ_IDLE: begin
                // Accept a start only in a valid mode
                if (s_d.start && (s_d.mode == `ADCSQ_MODE_SINGLE ||
                                  s_d.mode == `ADCSQ_MODE_REPEAT)) begin
                    go        = 1'b1;
                    s_d.start = 1'b0;
                    s_d.busy  = 1'b1;
                    s_d.eoc   = 1'b0;
                    s_d.cnt   = conv_len(s_d.tsel) - 11'h001;
                    s_d.st    = ADCSQ_CONV;
                end
            end
            ADCSQ_CONV: begin
                // Count down; zero marks the completing edge
                if (s_q.cnt == 11'h000) begin
                    comp = 1'b1;
                    // Lower byte read mid-pair: keep old value, drop event
                    if (!s_d.lo_rd) begin
                        s_d.res = i_analog_code;
                        s_d.eoc = 1'b1;
                        s_d.irq = 1'b1;
                    end
                    // Repeat reloads at once, single parks
                    if (s_q.mode == `ADCSQ_MODE_REPEAT) begin
                        s_d.cnt = conv_len(s_q.tsel) - 11'h001;
                    end else begin
                        s_d.busy = 1'b0;
                        s_d.st   = ADCSQ_IDLE;
                    end
                end else begin
                    s_d.cnt = s_q.cnt - 11'h001;
                end
            end
            default: s_d.st = ADCSQ_IDLE;
        endcase
        // Mode 00 forces a stop and clears results
        if (stop0) begin
            s_d.st    = ADCSQ_IDLE;
            s_d.busy  = 1'b0;
            s_d.eoc   = 1'b0;
            s_d.res   = 10'h000;
            s_d.lo_rd = 1'b0;
            s_d.irq   = 1'b0;
        end
        // Low-power entry wins over every written field, flag and result but channel and time select
        // Reference opens too, as it follows the input enable
        if (i_low_power) begin
            s_d.st    = ADCSQ_IDLE;
            s_d.start = 1'b0;
            s_d.mode  = `ADCSQ_MODE_OFF;
            s_d.ain   = 1'b0;
            s_d.eoc   = 1'b0;
            s_d.busy  = 1'b0;
            s_d.res   = 10'h000;
            s_d.lo_rd = 1'b0;
            s_d.irq   = 1'b0;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            // Everything off, waitrequest high
            s_q        <= '0;
            s_q.st     <= ADCSQ_IDLE;
            s_q.wait_r <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign o_avs_readdata        = s_q.rdata;
    assign o_avs_waitrequest     = s_q.wait_r;
    assign o_conv_done_irq       = s_q.irq;
    assign o_conv_busy_flag      = s_q.busy;
    assign o_channel_select      = s_q.chan;
    assign o_analog_input_enable = s_q.ain;
    assign o_ref_connect         = s_q.ain;

    // Checks: one clock domain, quiet during reset
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    // A start that nothing else overrides this edge
    sequence s_launch;
        go && !stop0 && !i_low_power;
    endsequence

    // Flags and results all back at zero
    sequence s_all_clear;
        !s_q.busy && !s_q.eoc && s_q.res == 10'h000;
    endsequence

    // Sequencer parked with no conversion running
    sequence s_parked;
        !o_conv_busy_flag && s_q.st == ADCSQ_IDLE;
    endsequence

    // Low-power entry seen while a conversion runs
    sequence s_lp_abort;
        s_q.busy && i_low_power;
    endsequence

    // Completion that falls inside an open result pair
    sequence s_pair_open_done;
        comp && s_q.lo_rd && !(acc_r && idx == `ADCSQ_IDX_RES_HI) &&
        !stop0 && !i_low_power;
    endsequence

    // Launch enters the conversion state with busy set
    start_launch_a: assert property (s_launch |=> s_q.busy && s_q.st == ADCSQ_CONV)
        else $error("start did not launch a conversion");

    // Launch consumes the pending start request
    start_clear_a: assert property (s_launch |=> !s_q.start)
        else $error("start bit did not clear on launch");

    // Bit 7 of control one with a valid mode launches from idle
    start_bit_a: assert property (acc_w && i_avs_byteenable[0] &&
                                  idx == `ADCSQ_IDX_CR1 &&
                                  i_avs_writedata[`ADCSQ_START_BIT] &&
                                  i_avs_writedata[`ADCSQ_MODE_LO] &&
                                  s_q.st == ADCSQ_IDLE && !i_low_power |=> o_conv_busy_flag)
        else $error("start bit did not launch");

    // Completion pulse comes with a stored result and a set flag
    done_store_a: assert property (o_conv_done_irq |-> s_q.eoc &&
                                   s_q.res == $past(i_analog_code))
        else $error("completion did not store result and flag");

    // Completion pulse lasts one cycle and follows a completion
    irq_pulse_a: assert property (o_conv_done_irq |-> $past(comp) ##1 !o_conv_done_irq)
        else $error("completion pulse malformed");

    // Upper result read clears the end flag
    upper_clear_a: assert property (acc_r && idx == `ADCSQ_IDX_RES_HI && !comp
                                    && !go |=> !s_q.eoc)
        else $error("upper read left end flag set");

    // New start clears an unread flag and keeps the result
    restart_clear_a: assert property (s_launch |=> !s_q.eoc ##0 $stable(s_q.res))
        else $error("restart kept end flag or changed result");

    // Result stands while a conversion counts down
    result_hold_a: assert property (s_q.st == ADCSQ_CONV && s_q.cnt != 11'h000 &&
                                    !stop0 && !i_low_power |=> $stable(s_q.res))
        else $error("result changed during conversion");

    // Upper result byte carries only the top two code bits
    res_split_a: assert property (acc_r && idx == `ADCSQ_IDX_RES_HI |->
                                  o_avs_readdata[31:2] == 30'h00000000)
        else $error("upper result byte wider than two bits");

    // Low power clears start, mode, input enable, flags and results
    lowpwr_clear_a: assert property (i_low_power |=> s_all_clear and
                                     (s_q.mode == `ADCSQ_MODE_OFF && !s_q.start &&
                                      !o_ref_connect && s_q.st == ADCSQ_IDLE))
        else $error("low-power entry did not clear state");

    // Low power mid-conversion abandons it at once
    abort_conv_a: assert property (s_lp_abort |=> s_parked ##1 !o_conv_done_irq)
        else $error("conversion not abandoned in low power");

    // Low power mid-conversion opens the reference
    ref_open_a: assert property (s_lp_abort |=> !o_ref_connect && !o_analog_input_enable)
        else $error("reference left connected in low power");

    // Leaving low power starts nothing by itself
    no_resume_a: assert property ($fell(i_low_power) && !acc_w |-> !s_q.busy ##1
                                  !s_q.busy)
        else $error("conversion resumed after low power");

    // Time code 010 loads a 156-cycle count
    time_sel_a: assert property ((s_launch and (s_d.tsel == 3'h2)) |=>
                                 s_q.cnt == `ADCSQ_CYC_T2 - 11'h001)
        else $error("time code 010 not 156 cycles");

    // Mode 10 leaves a start pending and idle
    mode_refuse_a: assert property (s_q.st == ADCSQ_IDLE && s_q.start &&
                                    s_q.mode == 2'h2 && !acc_w |=> !s_q.busy)
        else $error("start accepted in invalid mode");

    // Single mode drops busy at completion
    single_end_a: assert property (comp && s_q.mode == `ADCSQ_MODE_SINGLE &&
                                   !i_low_power |=> s_parked)
        else $error("busy stayed set after single conversion");

    // Busy rises only through an accepted start
    busy_cause_a: assert property ($rose(o_conv_busy_flag) |-> $past(go))
        else $error("busy rose without a start");

    // Repeat mode runs on after each completion
    repeat_next_a: assert property (comp && s_q.mode == `ADCSQ_MODE_REPEAT &&
                                    !stop0 && !i_low_power |=> s_q.busy)
        else $error("repeat mode did not continue");

    // Mode 00 stops and clears
    mode_stop_a: assert property (stop0 && !i_low_power |=> s_all_clear)
        else $error("mode 00 did not stop and clear");

    // Lower result read leaves the end flag set
    lower_keep_a: assert property (acc_r && idx == `ADCSQ_IDX_RES_LO && s_q.eoc &&
                                   !i_low_power |=> s_q.eoc)
        else $error("lower read changed end flag");

    // Completion inside an open pair keeps the old result, no pulse
    pair_hold_a: assert property (s_pair_open_done |=> $stable(s_q.res) && !o_conv_done_irq)
        else $error("open result pair overwritten");

endmodule

`default_nettype wire

// ### bench/adcsq_core_model.sv
// Behavioural analog core and input pins facing the sequencer.
// Assumes the bench sets the pin level; code is {channel, level}.
`timescale 1ns/100ps
`default_nettype none

module adcsq_core_model (
    input  wire logic       i_ref_clk, // Core clock
    input  wire logic       i_resetn,  // Async reset, low
    input  wire logic [3:0] i_chan,    // Channel from sequencer
    input  wire logic       i_ain,     // Input switch
    input  wire logic [5:0] i_level,   // Pin level from bench
    output logic      [9:0] o_code     // Code to sequencer
);
    // A switched-off input toggles, so a stale code never passes
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) o_code <= 10'h155;
        else if (i_ain) o_code <= {i_chan, i_level};
        else o_code <= ~o_code;
    end
endmodule

`default_nettype wire

// ### bench/tb_adc_conversion_sequencer.sv
// Self-checking bench of the conversion sequencer.
// Assumes the core model answers with {channel, level}.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module tb_adc_conversion_sequencer;
    import adcsq_pkg::*;
    localparam logic [5:0] C1 = `ADCSQ_IDX_CR1;
    localparam logic [5:0] C2 = `ADCSQ_IDX_CR2;
    localparam logic [5:0] RL = `ADCSQ_IDX_RES_LO;
    localparam logic [5:0] RH = `ADCSQ_IDX_RES_HI;
    logic        clk = 1'b0;   // Core clock
    logic        rstn = 1'b0;  // Reset, low
    logic [7:0]  adr = 8'h00;  // Bus address
    logic        rd = 1'b0;    // Read strobe
    logic        wr = 1'b0;    // Write strobe
    logic [31:0] wd = 32'h0;   // Write data
    logic        lp = 1'b0;    // Low-power mode
    logic [5:0]  lvl = 6'h00;  // Pin level
    logic [31:0] rdat;         // Read data
    logic        wreq;         // Waitrequest
    logic        irq;          // Completion pulse
    logic        busy;         // Busy output
    logic [3:0]  chan;         // Channel output
    logic        ain;          // Input enable output
    logic        refc;         // Reference switch
    logic [9:0]  code;         // Core code
    logic [31:0] r;            // Last read data
    logic [3:0]  ch;           // Channel in use
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          n;
    int          prev;
    int          exp_res;      // Model of stored result
    int          lens[8] = '{39, 78, 156, 312, 624, 1248, 1248, 1248};

    adcsq_seq dut (.i_ref_clk(clk), .i_resetn(rstn), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .i_analog_code(code), .i_low_power(lp),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_conv_done_irq(irq),
        .o_conv_busy_flag(busy), .o_channel_select(chan),
        .o_analog_input_enable(ain), .o_ref_connect(refc));
    adcsq_core_model core (.i_ref_clk(clk), .i_resetn(rstn), .i_chan(chan),
        .i_ain(ain), .i_level(lvl), .o_code(code));

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk);
        adr <= {idx, 2'b00};
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        do @(posedge clk); while (wreq !== 1'b0);
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Edges until the completion pulse is seen
    task automatic wait_irq(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (irq !== 1'b1 && k < 3000);
    endtask

    // Configure, set time, then start; model notes the result
    task automatic conv(input logic [1:0] m, input logic [2:0] t);
        ch = 4'($urandom);
        lvl <= 6'($urandom);
        bus(1'b1, C1, {1'b0, m, 1'b1, ch});
        bus(1'b1, C2, {5'h0, t});
        bus(1'b1, C1, {1'b1, m, 1'b1, ch});
        exp_res = {ch, lvl};
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        void'($urandom(1));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, 6'h00, 8'h00);
        `CHK(r, 32'h0)
        // Single mode over every time code
        for (int t = 0; t < 8; t++) begin
            conv(2'b01, 3'(t));
            wait_irq(n);
            `CHK(n, lens[t] + 1)
            `CHK(busy, 1'b0)
            bus(1'b0, RL, 8'h00);
            `CHK(r, 32'(exp_res % 256))
            bus(1'b0, C2, 8'h00);
            `CHK(r[7:6], 2'b10)
            bus(1'b0, RH, 8'h00);
            `CHK(r, 32'(exp_res / 256))
            bus(1'b0, C2, 8'h00);
            `CHK(r[7], 1'b0)
        end
        $display("single mode test done");
        // Restart before the result is read
        conv(2'b01, 3'd0);
        wait_irq(n);
        prev = exp_res;
        conv(2'b01, 3'd5);
        bus(1'b0, C2, 8'h00);
        `CHK(r[7:6], 2'b01)
        bus(1'b0, RL, 8'h00);
        `CHK(r, 32'(prev % 256))
        bus(1'b0, RH, 8'h00);
        `CHK(r, 32'(prev / 256))
        wait_irq(n);
        bus(1'b0, RL, 8'h00);
        `CHK(r, 32'(exp_res % 256))
        bus(1'b0, RH, 8'h00);
        `CHK(r, 32'(exp_res / 256))
        $display("restart test done");
        // Repeat mode, then stop by mode 00
        conv(2'b11, 3'd0);
        wait_irq(n);
        `CHK(n, 40)
        `CHK(busy, 1'b1)
        wait_irq(n);
        `CHK(n, 39)
        // Completion inside an open result pair is dropped
        prev = exp_res;
        lvl <= ~lvl;
        bus(1'b0, RL, 8'h00);
        repeat (45) @(posedge clk);
        bus(1'b0, RL, 8'h00);
        `CHK(r, 32'(prev % 256))
        bus(1'b0, RH, 8'h00);
        `CHK(r, 32'(prev / 256))
        bus(1'b1, C1, {3'b000, 1'b1, ch});
        @(posedge clk);
        `CHK(busy, 1'b0)
        bus(1'b0, C2, 8'h00);
        `CHK(r[7:6], 2'b00)
        bus(1'b0, RL, 8'h00);
        `CHK(r, 32'h0)
        // Start with mode 10 is refused
        bus(1'b1, C1, {3'b110, 1'b1, ch});
        repeat (50) @(posedge clk);
        `CHK(busy, 1'b0)
        bus(1'b1, C1, 8'h00);
        $display("repeat and stop test done");
        // Low-power entry in mid conversion
        conv(2'b01, 3'd0);
        wait_irq(n);
        conv(2'b01, 3'd5);
        repeat (20) @(posedge clk);
        lp <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(busy, 1'b0)
        `CHK(refc, 1'b0)
        `CHK(ain, 1'b0)
        lp <= 1'b0;
        bus(1'b0, C1, 8'h00);
        `CHK(r[7:4], 4'h0)
        bus(1'b0, C2, 8'h00);
        `CHK(r[7:6], 2'b00)
        bus(1'b0, RL, 8'h00);
        `CHK(r, 32'h0)
        wait_irq(n);
        `CHK(n, 3000)
        $display("low-power test done");
        report_and_stop();
    end
endmodule

`default_nettype wire
